// ==== logic/dual_dac_cmd_pkg.sv ====
// Purpose: Shared constants for the dual converter serial command logic.
// Assumes: Serial word of 16 bits, command nibble first, each field MSB first.
// Notes:   Command codes select input loads, output transfer and sleep state.
package dual_dac_cmd_pkg;
    localparam int unsigned WORD_WIDTH   = 16;
    localparam int unsigned CMD_WIDTH    = 4;
    localparam int unsigned CODE_WIDTH   = 10;
    localparam int unsigned FILL_WIDTH   = 2;
    localparam int unsigned CMD_MSB      = 15;
    localparam int unsigned CMD_LSB      = 12;
    localparam int unsigned CODE_MSB     = 11;
    localparam int unsigned CODE_LSB     = 2;
    localparam int unsigned CNT_WIDTH    = 5;
    localparam logic [CNT_WIDTH-1:0]  BITS_PER_WORD = 5'h10;
    localparam logic [CODE_WIDTH-1:0] CODE_RESET    = 10'h000;
    localparam logic [WORD_WIDTH-1:0] WORD_RESET    = 16'h0000;
    localparam logic                  CSL_IDLE_LEVEL = 1'b1;
    localparam int unsigned FULL_SCALE_STEPS = 1024;

    localparam logic [CMD_WIDTH-1:0] CMD_NOP        = 4'h0;
    localparam logic [CMD_WIDTH-1:0] CMD_LOAD_A     = 4'h1;
    localparam logic [CMD_WIDTH-1:0] CMD_LOAD_B     = 4'h2;
    localparam logic [CMD_WIDTH-1:0] CMD_UPDATE     = 4'h8;
    localparam logic [CMD_WIDTH-1:0] CMD_LOAD_A_UPD = 4'h9;
    localparam logic [CMD_WIDTH-1:0] CMD_LOAD_B_UPD = 4'ha;
    localparam logic [CMD_WIDTH-1:0] CMD_WAKE       = 4'hd;
    localparam logic [CMD_WIDTH-1:0] CMD_SLEEP      = 4'he;
    localparam logic [CMD_WIDTH-1:0] CMD_LOAD_ALL   = 4'hf;
endpackage

// ==== logic/pin_sync.sv ====
// Purpose: Two-flop synchroniser with edge detection for one pin.
// Assumes: Pin changes slowly relative to the sampling clock.
// Notes:   Edges are found on the second stage and a third flop only.
//          Reset loads the pin's idle level so that no false edge follows it.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_ff <= IDLE_LEVEL;
            sync_ff <= IDLE_LEVEL;
            prev_ff <= IDLE_LEVEL;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_o = sync_ff;
    assign rise_o  = sync_ff & ~prev_ff;
    assign fall_o  = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ==== logic/dual_dac_serial_command_logic.sv ====
// Purpose: Serial command decoder and double-buffered registers of a dual converter.
// Assumes: Serial clock well below a quarter of ref_clk_i; all pins sampled twice.
// Notes:   Chip select reset state is high so no word starts during reset.
//
// How it works
// - Select low: shift data on serial rising edge.
// - Word is command, code, two filler bits.
// - Select rising after full word runs command.
// - Select high: serial edges shift nothing.
// - Each channel: input and output register.
// - Output registers always update both together.
// - Sleep command disables analog, keeps registers.
// - Sleep ignores code field, registers unchanged.
// - Waking restores held outputs not rewritten.
// - Loads keep sleep; update command wakes, transfers.
// - Power-up leaves both outputs at zero.
// - Output code is unsigned fraction of reference.
// - No-operation command changes nothing.
// - Load one channel, transfer both, wake.
// - Wake command changes no register.
// - Same code to both, transfer, wake.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_command_logic
    import dual_dac_cmd_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  chip_select_load_i,
    input  wire logic                  serial_clock_i,
    input  wire logic                  serial_data_i,
    output logic [CODE_WIDTH-1:0]      channel_a_output_o,
    output logic [CODE_WIDTH-1:0]      channel_b_output_o,
    output logic [CODE_WIDTH-1:0]      input_a_o,
    output logic [CODE_WIDTH-1:0]      input_b_o,
    output logic                       sleep_o,
    output logic                       analog_enable_o,
    output logic                       output_hiz_o,
    output logic                       word_done_o,
    output logic                       word_error_o
);

    // =====================================================================
    // Command decode
    // =====================================================================
    typedef struct packed {
        logic load_a;
        logic load_b;
        logic transfer;
        logic wake;
        logic sleep;
    } cmd_action_type;

    // Decode is used for both the executed word and the error flag.
    function automatic cmd_action_type decode_cmd(input logic [CMD_WIDTH-1:0] cmd);
        cmd_action_type act;
        act = '0;
        case (cmd)
            CMD_NOP: begin
                act = '0;
            end
            CMD_LOAD_A: begin
                act.load_a = 1'b1;
            end
            CMD_LOAD_B: begin
                act.load_b = 1'b1;
            end
            CMD_UPDATE: begin
                act.transfer = 1'b1;
                act.wake     = 1'b1;
            end
            CMD_LOAD_A_UPD: begin
                act.load_a   = 1'b1;
                act.transfer = 1'b1;
                act.wake     = 1'b1;
            end
            CMD_LOAD_B_UPD: begin
                act.load_b   = 1'b1;
                act.transfer = 1'b1;
                act.wake     = 1'b1;
            end
            CMD_WAKE: begin
                act.wake = 1'b1;
            end
            CMD_SLEEP: begin
                act.sleep = 1'b1;
            end
            CMD_LOAD_ALL: begin
                act.load_a   = 1'b1;
                act.load_b   = 1'b1;
                act.transfer = 1'b1;
                act.wake     = 1'b1;
            end
            default: begin
                act = '0;
            end
        endcase
        return act;
    endfunction

    // The no-operation code decodes to no action, so it is named explicitly.
    function automatic logic is_known_cmd(input logic [CMD_WIDTH-1:0] cmd);
        return (cmd == CMD_NOP) || (decode_cmd(cmd) != '0);
    endfunction

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    logic csl_level;
    logic csl_rise;
    logic csl_fall;
    logic sck_rise;
    logic din_level;

    // The select pin idles high; flops reset low would report a false rising
    // edge, and so a refused word, just after reset.
    pin_sync #(
        .IDLE_LEVEL (CSL_IDLE_LEVEL)
    ) u_sync_csl (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (chip_select_load_i),
        .level_o   (csl_level),
        .rise_o    (csl_rise),
        .fall_o    (csl_fall)
    );

    pin_sync u_sync_sck (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (serial_clock_i),
        .level_o   (),
        .rise_o    (sck_rise),
        .fall_o    ()
    );

    // Data passes the same two-flop delay as the clock, so it is sampled as
    // it stood at the serial rising edge.
    pin_sync u_sync_din (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (serial_data_i),
        .level_o   (din_level),
        .rise_o    (),
        .fall_o    ()
    );

    // =====================================================================
    // Shift register
    // =====================================================================
    logic [WORD_WIDTH-1:0] shift_ff;
    logic [CNT_WIDTH-1:0]  count_ff;

    // The select level lags its pin by the same two flops as the serial clock,
    // so the gate and the detected edge line up.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shift_ff <= WORD_RESET;
        end else if (sck_rise && !csl_level) begin
            shift_ff <= {shift_ff[WORD_WIDTH-2:0], din_level};
        end
    end

    // The count saturates so that a word longer than sixteen bits still
    // executes on the last sixteen shifted in, as a plain shift register would.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            count_ff <= '0;
        end else if (csl_fall) begin
            count_ff <= '0;
        end else if (sck_rise && !csl_level && count_ff != BITS_PER_WORD) begin
            count_ff <= count_ff + CNT_WIDTH'(1);
        end
    end

    // =====================================================================
    // Execute on chip select rising
    // =====================================================================
    logic [CMD_WIDTH-1:0]  rx_cmd;
    logic [CODE_WIDTH-1:0] rx_code;
    logic                  word_full;
    logic                  exec;
    cmd_action_type        act;

    // Sixteen or more edges since select fell make a word that executes.
    assign rx_cmd    = shift_ff[CMD_MSB:CMD_LSB];
    assign rx_code   = shift_ff[CODE_MSB:CODE_LSB];
    assign word_full = (count_ff == BITS_PER_WORD);
    assign exec      = csl_rise && word_full;
    assign act       = decode_cmd(rx_cmd);

    // =====================================================================
    // Holding and output registers
    // =====================================================================
    logic [CODE_WIDTH-1:0] in_a_ff;
    logic [CODE_WIDTH-1:0] in_b_ff;
    logic [CODE_WIDTH-1:0] out_a_ff;
    logic [CODE_WIDTH-1:0] out_b_ff;
    logic [CODE_WIDTH-1:0] nxt_in_a;
    logic [CODE_WIDTH-1:0] nxt_in_b;
    logic                  sleep_ff;

    always_comb begin
        nxt_in_a = in_a_ff;
        nxt_in_b = in_b_ff;
        if (exec && act.load_a) begin
            nxt_in_a = rx_code;
        end
        if (exec && act.load_b) begin
            nxt_in_b = rx_code;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            in_a_ff <= CODE_RESET;
            in_b_ff <= CODE_RESET;
        end else begin
            in_a_ff <= nxt_in_a;
            in_b_ff <= nxt_in_b;
        end
    end

    // Transfer uses the new input values, so a combined load-and-update
    // lands the fresh code in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            out_a_ff <= CODE_RESET;
            out_b_ff <= CODE_RESET;
        end else if (exec && act.transfer) begin
            out_a_ff <= nxt_in_a;
            out_b_ff <= nxt_in_b;
        end
    end

    // =====================================================================
    // Sleep state
    // =====================================================================
    // No code both sleeps and wakes, so the branch order only matters if the
    // command table ever grows.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sleep_ff <= 1'b0;
        end else if (exec && act.sleep) begin
            sleep_ff <= 1'b1;
        end else if (exec && act.wake) begin
            sleep_ff <= 1'b0;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            channel_a_output_o <= CODE_RESET;
            channel_b_output_o <= CODE_RESET;
            input_a_o          <= CODE_RESET;
            input_b_o          <= CODE_RESET;
        end else begin
            channel_a_output_o <= out_a_ff;
            channel_b_output_o <= out_b_ff;
            input_a_o          <= in_a_ff;
            input_b_o          <= in_b_ff;
        end
    end

    // The channel codes keep standing during sleep; the high-impedance flag
    // tells the analog side to release the pins instead.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sleep_o         <= 1'b0;
            analog_enable_o <= 1'b1;
            output_hiz_o    <= 1'b0;
        end else begin
            sleep_o         <= sleep_ff;
            analog_enable_o <= ~sleep_ff;
            output_hiz_o    <= sleep_ff;
        end
    end

    // Every full word pulses done, a no-operation and a reserved code included.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            word_done_o <= 1'b0;
        end else begin
            word_done_o <= exec;
        end
    end

    // A short word is reported and never executed; a reserved code is reported and executes with no action.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            word_error_o <= 1'b0;
        end else begin
            word_error_o <= csl_rise && (!word_full || !is_known_cmd(rx_cmd));
        end
    end

endmodule
`default_nettype wire

// ==== bench/dual_dac_cmd_props.sv ====
// Purpose: Port checker of the serial command logic.
// Assumes: Reset is held for several cycles.
// Notes:   Register ports only change the cycle after an executed word.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_cmd_props
    import dual_dac_cmd_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic       chip_select_load_i,
    input wire logic       serial_clock_i,
    input wire logic       serial_data_i,
    input wire logic [9:0] channel_a_output_o,
    input wire logic [9:0] channel_b_output_o,
    input wire logic [9:0] input_a_o,
    input wire logic [9:0] input_b_o,
    input wire logic       sleep_o,
    input wire logic       analog_enable_o,
    input wire logic       output_hiz_o,
    input wire logic       word_done_o,
    input wire logic       word_error_o
);
    // =====
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    sequence regs_hold;
        $stable({channel_a_output_o, channel_b_output_o, input_a_o, input_b_o, sleep_o});
    endsequence
    sequence select_held;
        chip_select_load_i && $past(chip_select_load_i, 2);
    endsequence
    AST_RESET_CLEAR: assert property (
        $fell(srst_i) |-> {channel_a_output_o, channel_b_output_o, input_a_o, input_b_o,
        sleep_o} == 41'h0) else $error("registers not clear after reset");
    AST_QUIET_AFTER_RESET: assert property (
        $fell(srst_i) |-> (!word_error_o) [*8]) else $error("error pulse right after reset");
    AST_OUT_CAUSE: assert property (
        $changed({channel_a_output_o, channel_b_output_o}) |-> $past(word_done_o) && !sleep_o
        && channel_a_output_o == input_a_o && channel_b_output_o == input_b_o)
        else $error("output change without joint transfer");
    AST_IN_CAUSE: assert property (
        $changed({input_a_o, input_b_o}) |-> $past(word_done_o))
        else $error("input register changed without a word");
    AST_SLEEP_CAUSE: assert property (
        $changed(sleep_o) |-> $past(word_done_o)) else $error("sleep changed without a word");
    AST_HIZ_MATCH: assert property (
        output_hiz_o == sleep_o) else $error("high impedance flag differs from sleep");
    AST_ANALOG_MATCH: assert property (
        analog_enable_o != sleep_o) else $error("analog enable equals sleep");
    AST_REFUSE_HOLD: assert property (
        word_error_o |=> regs_hold [*2]) else $error("refused word changed a register");
    AST_DONE_SELECT: assert property (
        word_done_o |-> select_held) else $error("word executed while select low");
endmodule
bind dual_dac_serial_command_logic dual_dac_cmd_props u_dual_dac_cmd_props (
    .ref_clk_i, .srst_i, .chip_select_load_i, .serial_clock_i, .serial_data_i,
    .channel_a_output_o, .channel_b_output_o, .input_a_o, .input_b_o, .sleep_o,
    .analog_enable_o, .output_hiz_o, .word_done_o, .word_error_o);
`default_nettype wire

// ==== bench/host_serial_model.sv ====
// Purpose: Host that shifts words into the command logic.
// Assumes: Pins change on falling clock edges; 80 ns serial period.
// Notes:   A bit count of zero clocks 16 bits with select kept high.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    input  wire logic        ref_clk_i,
    input  wire logic        start_i,
    input  wire logic [15:0] word_i,
    input  wire logic [4:0]  nbits_i,
    output logic             busy_o,
    output logic             chip_select_load_o,
    output logic             serial_clock_o,
    output logic             serial_data_o
);
    // =====
    // Sequencer
    int n;
    initial begin
        busy_o = 1'b0;
        chip_select_load_o = 1'b1;
        serial_clock_o = 1'b0;
        serial_data_o = 1'b0;
        forever begin
            @(posedge start_i);
            @(negedge ref_clk_i);
            busy_o = 1'b1;
            chip_select_load_o = (nbits_i == 5'h0); // clock is low here
            n = (nbits_i == 5'h0) ? 16 : int'(nbits_i);
            repeat (8) @(negedge ref_clk_i);
            for (int i = 0; i < n; i++) begin
                serial_data_o = word_i[15 - i];
                repeat (4) @(negedge ref_clk_i);
                serial_clock_o = 1'b1;
                repeat (8) @(negedge ref_clk_i);
                serial_clock_o = 1'b0;
                serial_data_o = ~serial_data_o;
                repeat (4) @(negedge ref_clk_i);
            end
            chip_select_load_o = 1'b1;
            repeat (24) @(negedge ref_clk_i);
            busy_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench of the serial command logic.
// Assumes: Host model drives the pins on falling clock edges.
// Notes:   Expected registers come from a small model of the command table.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dual_dac_cmd_pkg::*;
    logic       ref_clk_i, srst_i, start, busy, cs, sck, sdi, slp, aen, hiz;
    logic       done, err, done_seen, err_seen, es;
    logic [15:0] word;
    logic [4:0] nbits;
    logic [9:0] ch_a, ch_b, in_a, in_b, ea, eb, oa, ob;
    int         bad_count, compares, cycles;
    // =====
    // Harness
    dual_dac_serial_command_logic u_dual_dac_serial_command_logic (
        .ref_clk_i, .srst_i, .chip_select_load_i(cs), .serial_clock_i(sck),
        .serial_data_i(sdi), .channel_a_output_o(ch_a), .channel_b_output_o(ch_b),
        .input_a_o(in_a), .input_b_o(in_b), .sleep_o(slp), .analog_enable_o(aen),
        .output_hiz_o(hiz), .word_done_o(done), .word_error_o(err));
    host_serial_model u_host_serial_model (
        .ref_clk_i, .start_i(start), .word_i(word), .nbits_i(nbits), .busy_o(busy),
        .chip_select_load_o(cs), .serial_clock_o(sck), .serial_data_o(sdi));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (done === 1'b1) done_seen <= 1'b1;
        if (err === 1'b1) err_seen <= 1'b1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic check_regs();
        check({6'h0, ch_a}, {6'h0, oa});
        check({6'h0, ch_b}, {6'h0, ob});
        check({6'h0, in_a}, {6'h0, ea});
        check({6'h0, in_b}, {6'h0, eb});
        check({13'h0, slp, aen, hiz}, {13'h0, es, !es, es});
    endtask
    task automatic send(input logic [3:0] c, input logic [9:0] code, input logic [4:0] n);
        @(negedge ref_clk_i);
        done_seen = 1'b0;
        err_seen = 1'b0;
        word = {c, code, 2'b11};
        nbits = n;
        start = 1'b1;
        wait (busy === 1'b1);
        @(negedge ref_clk_i);
        start = 1'b0;
        wait (busy === 1'b0);
    endtask
    task automatic run(input logic [3:0] c, input logic [9:0] code);
        logic rsv;
        send(c, code, 5'h10);
        rsv = !(c inside {CMD_NOP, CMD_LOAD_A, CMD_LOAD_B, CMD_UPDATE, CMD_LOAD_A_UPD,
                          CMD_LOAD_B_UPD, CMD_WAKE, CMD_SLEEP, CMD_LOAD_ALL});
        if (c inside {CMD_LOAD_A, CMD_LOAD_A_UPD, CMD_LOAD_ALL}) ea = code;
        if (c inside {CMD_LOAD_B, CMD_LOAD_B_UPD, CMD_LOAD_ALL}) eb = code;
        if (c == CMD_SLEEP) es = 1'b1;
        if (c == CMD_WAKE) es = 1'b0;
        if (c inside {CMD_UPDATE, CMD_LOAD_A_UPD, CMD_LOAD_B_UPD, CMD_LOAD_ALL}) begin
            oa = ea;
            ob = eb;
            es = 1'b0;
        end
        check({14'h0, done_seen, err_seen}, {14'h0, 1'b1, rsv});
        check_regs();
    endtask
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            run(4'(c), c[0] ? 10'h3ff : 10'h155 ^ 10'(c));
        end
        $display("test codes done");
    endtask
    task automatic t_refuse();
        send(CMD_LOAD_ALL, 10'h111, 5'hc);
        check({14'h0, done_seen, err_seen}, 16'h1);
        check_regs();
        send(CMD_LOAD_ALL, 10'h222, 5'h0);
        check({14'h0, done_seen, err_seen}, 16'h0);
        check_regs();
        $display("test refuse done");
    endtask
    task automatic t_sleep();
        run(CMD_SLEEP, 10'h2aa);
        run(CMD_LOAD_A, 10'h0f0);
        run(CMD_WAKE, 10'h001);
        run(CMD_SLEEP, 10'h000);
        run(CMD_LOAD_B, 10'h00f);
        run(CMD_UPDATE, 10'h3c3);
        $display("test sleep done");
    endtask
    task automatic finish_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        srst_i = 1'b1;
        start = 1'b0;
        word = 16'h0000;
        nbits = 5'h10;
        {done_seen, err_seen, ea, eb, oa, ob, es} = '0;
        bad_count = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(negedge ref_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check_regs();
        t_codes();
        t_refuse();
        t_sleep();
        finish_test();
    end
endmodule
`default_nettype wire
